/* include/msdff_pkg.sv */
`default_nettype none
package msdff_pkg;

  // ****************************************
  // Pin synchroniser
  // ****************************************
  localparam int SYNC_STAGES = 3;
  localparam int PIN_COUNT   = 5;

  // Bit positions of the pins in the synchroniser vector
  localparam int PIN_CLK1   = 0;
  localparam int PIN_CLK2   = 1;
  localparam int PIN_DATA   = 2;
  localparam int PIN_PRESET = 3;
  localparam int PIN_CLEAR  = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic SYNC_RST   = 1'h0;
  localparam logic MASTER_RST = 1'h0;
  localparam logic SLAVE_RST  = 1'h0;
  localparam logic CLK_RST    = 1'h0;

endpackage
`default_nettype wire

/* include/msdff_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface msdff_sync_if #(
  parameter int W = 5
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

/* rtl/msdff_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module msdff_pin_sync #(
  parameter int W      = msdff_pkg::PIN_COUNT,
  parameter int STAGES = msdff_pkg::SYNC_STAGES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Pins in, filtered levels out
  msdff_sync_if.filt       sig
);

  // ****************************************
  // One chain per pin
  // ****************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [STAGES-1:0] stage_reg;
    logic              clean_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        stage_reg <= {STAGES{msdff_pkg::SYNC_RST}};
      end else begin
        stage_reg <= {stage_reg[STAGES-2:0], sig.raw[i]};
      end
    end

    // First stage is left alone; only the later two vote
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        clean_reg <= msdff_pkg::SYNC_RST;
      end else if (stage_reg[STAGES-2] == stage_reg[STAGES-1]) begin
        clean_reg <= stage_reg[STAGES-2];
      end
    end

    assign sig.clean[i] = clean_reg;
  end

endmodule // msdff_pin_sync
`default_nettype wire

/* rtl/msdff_top.sv */
// Summary of operation
// - Both clock pins low: data loads master only, output holds.
// - Rising edge of OR of clock pins copies master into output stage.
// - Either clock pin high: master frozen, data ignored, output holds.
// - Preset and clear act without any clock edge and override clock and data.
// - Preset alone forces output high, clear alone low, both drive q and q_n low.
`timescale 1ns/1ps
`default_nettype none
module msdff_top (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Clock pins
  input  wire logic first_clock_in,
  input  wire logic second_clock_in,
  // Data and asynchronous controls
  input  wire logic data_in,
  input  wire logic preset_in,
  input  wire logic clear_in,
  // Outputs
  output var  logic q,
  output var  logic q_n
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  msdff_sync_if #(.W(msdff_pkg::PIN_COUNT)) pins ();

  assign pins.raw[msdff_pkg::PIN_CLK1]   = first_clock_in;
  assign pins.raw[msdff_pkg::PIN_CLK2]   = second_clock_in;
  assign pins.raw[msdff_pkg::PIN_DATA]   = data_in;
  assign pins.raw[msdff_pkg::PIN_PRESET] = preset_in;
  assign pins.raw[msdff_pkg::PIN_CLEAR]  = clear_in;

  msdff_pin_sync #(
    .W      (msdff_pkg::PIN_COUNT),
    .STAGES (msdff_pkg::SYNC_STAGES)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sig     (pins.filt)
  );

  logic eff_clk;
  logic d_clean;
  logic pre_clean;
  logic clr_clean;
  logic eff_clk_reg;
  logic clk_rise;
  logic master_reg;
  logic slave_reg;
  logic slave_n_reg;

  // ****************************************
  // Effective clock and its edge
  // ****************************************
  // Clocks are ORed
  assign eff_clk   = pins.clean[msdff_pkg::PIN_CLK1] | pins.clean[msdff_pkg::PIN_CLK2];
  assign d_clean   = pins.clean[msdff_pkg::PIN_DATA];
  assign pre_clean = pins.clean[msdff_pkg::PIN_PRESET];
  assign clr_clean = pins.clean[msdff_pkg::PIN_CLEAR];
  assign clk_rise  = eff_clk & ~eff_clk_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eff_clk_reg <= msdff_pkg::CLK_RST;
    end else begin
      eff_clk_reg <= eff_clk;
    end
  end

  // ****************************************
  // Master stage
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      master_reg <= msdff_pkg::MASTER_RST;
    end else if (!eff_clk) begin
      master_reg <= d_clean;
    end
  end

  // ****************************************
  // Slave stage
  // ****************************************
  // Controls are checked every cycle, not only at a clock edge, so a
  // preset or clear lands even while the clock pins stand still.
  // With both controls high the output is driven low on both rails.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slave_reg   <= msdff_pkg::SLAVE_RST;
      slave_n_reg <= ~msdff_pkg::SLAVE_RST;
    end else if (pre_clean || clr_clean) begin
      slave_reg   <= pre_clean & ~clr_clean;
      slave_n_reg <= clr_clean & ~pre_clean;
    end else if (clk_rise) begin
      slave_reg   <= master_reg;
      slave_n_reg <= ~master_reg;
    end
  end

  assign q   = slave_reg;
  assign q_n = slave_n_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence no_ctrl_s;
    !pre_clean && !clr_clean;
  endsequence

  sequence edge_free_s;
    clk_rise and no_ctrl_s;
  endsequence

  sequence hold_s;
    !clk_rise and no_ctrl_s;
  endsequence

  // Clock low for a cycle: the master has just sampled data
  sequence clk_low_s;
    !eff_clk;
  endsequence

  // Data taken while low, then handed on at the next rise
  sequence load_path_s;
    clk_low_s ##1 edge_free_s;
  endsequence

  sequence preset_only_s;
    pre_clean && !clr_clean;
  endsequence

  sequence clear_only_s;
    clr_clean && !pre_clean;
  endsequence

  sequence one_ctrl_s;
    preset_only_s or clear_only_s;
  endsequence

  // Two cycles of one control, so the forced level has had an edge to land
  sequence preset_run_s;
    preset_only_s ##1 preset_only_s;
  endsequence

  sequence clear_run_s;
    clear_only_s ##1 clear_only_s;
  endsequence

  master_follow_a : assert property (!eff_clk |=> master_reg == $past(d_clean))
    else $error("master did not follow data with clock low");

  slave_load_a : assert property (edge_free_s |=> q == $past(master_reg))
    else $error("output not loaded from master on clock rise");

  master_frozen_a : assert property (eff_clk |=> $stable(master_reg))
    else $error("master changed while clock high");

  output_hold_a : assert property (hold_s |=> $stable(q) && $stable(q_n))
    else $error("output changed without clock rise");

  preset_wins_a : assert property (pre_clean && !clr_clean && clk_rise |=> q && !q_n)
    else $error("clock edge overrode preset");

  preset_force_a : assert property (pre_clean && !clr_clean ##1 pre_clean |=> q [*1])
    else $error("preset did not force output high");

  clear_force_a : assert property (clr_clean && !pre_clean |=> !q && q_n)
    else $error("clear did not force output low");

  // Only the forbidden both-controls case may leave the rails equal
  rails_opposite_a : assert property (no_ctrl_s |=> q_n == !q)
    else $error("complement output disagrees");

  // ****************************************
  // Several-step checks
  // ****************************************
  // The output shows the data held two cycles before it
  load_through_a : assert property (load_path_s |=> q == $past(d_clean, 2))
    else $error("data sampled before the rise did not reach the output");

  // Master keeps the last value sampled while the clock was low
  pre_rise_a : assert property (clk_low_s ##1 eff_clk |-> master_reg == $past(d_clean))
    else $error("master lost the value sampled before the rise");

  clear_wins_a : assert property (clr_clean && !pre_clean && clk_rise |=> !q && q_n)
    else $error("clock edge overrode clear");

  // Whatever the clock and data do, a single control sets the level
  ctrl_wins_a : assert property (one_ctrl_s |=> q == $past(pre_clean))
    else $error("output not set by the active control");

  preset_hold_a : assert property (preset_run_s |-> q && !q_n)
    else $error("output left high level while preset held");

  clear_hold_a : assert property (clear_run_s |-> !q && q_n)
    else $error("output left low level while clear held");

  rise_once_a : assert property (clk_rise |=> !clk_rise)
    else $error("one clock rise seen on two cycles");

  rise_after_low_a : assert property (clk_rise |-> $past(!eff_clk))
    else $error("clock rise seen without a low cycle before it");

  // Releasing a control is not an edge: the forced level stays
  preset_release_a : assert property ($fell(pre_clean) && !clr_clean && !clk_rise |=> q)
    else $error("output moved when preset was released");

  clear_release_a : assert property ($fell(clr_clean) && !pre_clean && !clk_rise |=> !q)
    else $error("output moved when clear was released");

endmodule // msdff_top
`default_nettype wire

/* rtl/msdff_unused_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tb/msdff_pins.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Surrounding logic driving the pins
// ****************************************
module msdff_pins (
  // Clock
  input  wire logic ref_clk,
  // Pins
  output var  logic first_clock_in,
  output var  logic second_clock_in,
  output var  logic data_in,
  output var  logic preset_in,
  output var  logic clear_in
);
  initial begin
    {clear_in, preset_in, data_in, second_clock_in, first_clock_in} = 5'h00;
  end
  // Pin order {clear, preset, data, clock 2, clock 1}
  task automatic set_pins(input logic [4:0] v);
    @(posedge ref_clk);
    #1;
    {clear_in, preset_in} = {v[4] & ~v[3], v[3]};
    {data_in, second_clock_in, first_clock_in} = v[2:0];
    // Levels held long enough to clear the pin filter
    repeat (6) @(posedge ref_clk);
  endtask
endmodule // msdff_pins
`default_nettype wire

/* tb/msdff_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module msdff_top_tb;
  logic       ref_clk = 1'h0;
  logic       rst     = 1'h1;
  logic       c1, c2, d, p, c, q, q_n;
  logic       exp_q = 1'h0, mst = 1'h0, prev = 1'h0;
  logic [7:0] lf    = 8'h59;
  int         failures = 0, num_checks = 0, cyc = 0;

  always #5 ref_clk = ~ref_clk;

  msdff_top DUT (.ref_clk(ref_clk), .rst(rst), .first_clock_in(c1), .second_clock_in(c2),
    .data_in(d), .preset_in(p), .clear_in(c), .q(q), .q_n(q_n));
  msdff_pins drv (.ref_clk(ref_clk), .first_clock_in(c1), .second_clock_in(c2),
    .data_in(d), .preset_in(p), .clear_in(c));

  // ****************************************
  // Checking and expectation
  // ****************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic seen, input logic want);
    num_checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %b want %b", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Controls win over a simultaneous rise; master only follows data while clock low
  task automatic step(input logic [4:0] v);
    logic ceff;
    ceff = v[0] | v[1];
    drv.set_pins(v);
    if (v[3]) exp_q = 1'h1;
    else if (v[4]) exp_q = 1'h0;
    else if (ceff && !prev) exp_q = mst;
    if (!ceff) mst = v[2];
    prev = ceff;
    check(q, exp_q);
    check(q_n, ~exp_q);
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    check(q, 1'h0);
    check(q_n, 1'h1);
    step(5'h04);
    step(5'h05);
    step(5'h01);
    step(5'h00);
    step(5'h02);
    step(5'h08);
    step(5'h12);
    step(5'h00);
    step(5'h09);
    step(5'h01);
    $display("directed tests done");
    repeat (40) begin
      lf = lfsr(lf);
      step({lf[7:5] == 3'h7, lf[6:4] == 3'h0, lf[2:0]} & 5'h1f);
    end
    $display("random tests done");
    conclude();
  end
endmodule // msdff_top_tb
`default_nettype wire
